// [design/setl_top.v]
// scsi error terminate, residue and loopback datapath with its byte fifo
//
// Contract
// - input error: drop strobe, drain to empty
// - output error: drop strobe, halt host side
// - drain shows request flag or dma request
// - wide odd drain: last word padded
// - padded access leaves modcount equal datacount+1
// - entry command enters loopback mode
// - loopback: no bus drive, no bus sampling
// - loopback register feeds control inputs, select input reads zero
// - control state shows inputs and outputs
// - loopback parity input reads zero
// - message send captured into incoming buffer
// - message receive sourced from outgoing buffer
// - data send wraps incoming buffer
// - data receive reuses outgoing buffer cyclically
// - sync strobe timing from own id
`timescale 1ns/1ps
`include "setl_defines.vh"

// ================
// byte fifo, one or two bytes per side per cycle
module setl_fifo
#(
    parameter WIDTH = 8,
    parameter DEPTH = 8
)
(
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    input wire flush,
    // fill side
    input wire inValid,
    input wire inPair,
    input wire [WIDTH-1:0] inData,
    input wire [WIDTH-1:0] inData2,
    output wire inReady,
    output wire inReady2,
    // drain side
    input wire outReady,
    input wire outPair,
    output wire outValid,
    output wire outValid2,
    output wire [WIDTH-1:0] outData,
    output wire [WIDTH-1:0] outData2
);
    localparam AW = $clog2(DEPTH);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_r;
    reg [AW-1:0] rdPtr_r;
    reg [AW:0] cnt_r;
    wire doPush;
    wire doPop;
    wire [AW:0] pushN;
    wire [AW:0] popN;

    assign inReady = (cnt_r < DEPTH);
    assign inReady2 = (cnt_r < DEPTH - 1);
    assign outValid = (cnt_r != 0);
    assign outValid2 = (cnt_r > 1);
    assign outData = mem[rdPtr_r];
    assign outData2 = mem[rdPtr_r + 1'b1];
    assign doPush = inValid & (inPair ? inReady2 : inReady);
    assign doPop = outReady & (outPair ? outValid2 : outValid);
    assign pushN = {{(AW-1){1'b0}}, doPush & inPair, doPush & ~inPair};
    assign popN = {{(AW-1){1'b0}}, doPop & outPair, doPop & ~outPair};

    always @(posedge mclk)
    begin
        if (doPush)
        begin
            mem[wrPtr_r] <= inData;
            if (inPair)
                mem[wrPtr_r + 1'b1] <= inData2;
        end
    end

    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrPtr_r <= {AW{1'b0}};
            rdPtr_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            wrPtr_r <= flush ? {AW{1'b0}} : wrPtr_r + pushN[AW-1:0];
            rdPtr_r <= flush ? {AW{1'b0}} : rdPtr_r + popN[AW-1:0];
            cnt_r <= flush ? {(AW+1){1'b0}} : cnt_r + pushN - popN;
        end
    end
endmodule // setl_fifo

// ================
// transfer engine, terminate handling and loopback mode
module setl_top
(
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // register port
    input wire [7:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    output wire [15:0] regRdData,
    // dma port
    input wire dmaAck,
    input wire [15:0] dmaWrData,
    output wire dmaReq,
    output wire [15:0] dmaRdData,
    // error detection
    input wire errDetect,
    // scsi bus
    input wire [8:0] scsiCtlIn,
    input wire [7:0] scsiDataIn,
    input wire scsiParIn,
    output wire [7:0] scsiCtlOut,
    output wire [7:0] scsiCtlOe,
    output wire [7:0] scsiDataOut,
    output wire scsiParOut,
    output wire scsiDataOe
);
    localparam ST_IDLE = 3'h0;
    localparam ST_WAIT = 3'h1;
    localparam ST_HOLD = 3'h2;
    localparam ST_REL = 3'h3;
    localparam ST_TERM = 3'h4;

    reg [8:0] ctlSync1_r, ctlSync2_r;
    reg [7:0] datSync1_r, datSync2_r;
    reg parSync1_r, parSync2_r;
    reg [4:0] cfg_r;
    reg [7:0] len_r, loopIn_r, modCnt_r, dataCnt_r;
    reg [2:0] ownId_r, state_r, stateNxt;
    reg [3:0] syncTbl [0:7];
    reg [3:0] widthCnt_r;
    reg [8:0] remain_r;
    reg loopMode_r, dirIn_r, term_r, halt_r, ownStrb_r, ownStrbNxt, parLast_r;
    reg [4:0] outPtr_r, inPtr_r, swOutPtr_r, swInPtr_r;
    reg [7:0] outBuf [0:`SETL_MBUF_DEPTH-1];
    reg [7:0] inBuf [0:`SETL_MBUF_DEPTH-1];
    reg [15:0] rdData_r, dmaRdData_r;
    reg dmaReq_r, dataOe_r, parOut_r;
    reg [7:0] ctlOut_r, ctlOe_r, dataOut_r;
    reg evCap, evDone, goHold;
    wire target, wide, msgPh, useDma, peerStrb, errEv, busRst, busy;
    wire [8:0] ctlEff;
    wire [7:0] dataEff, ownBits, ctlState, outByte, strbBit;
    wire parEff;
    wire [7:0] fInData, fOutData, fOutData2;
    wire fInReady, fInReady2, fOutValid, fOutValid2;
    wire fInValid, fInPair, fOutReady, fOutPair;
    wire cmdWr, startIn, startOut, startAny;
    wire hostRd, hostWr, hostPop, hostPush, oddPad, xferFlag;
    wire [15:0] hostWrData, popWord;
    wire [5:0] residue;
    wire inBufWr;
    wire [7:0] inBufData;

    assign target = cfg_r[`SETL_CFG_TARGET];
    assign wide = cfg_r[`SETL_CFG_WIDE];
    assign msgPh = cfg_r[`SETL_CFG_MSG];
    assign useDma = cfg_r[`SETL_CFG_DMA];
    assign busy = (state_r != ST_IDLE);
    // ================
    // effective bus view
    assign ctlEff = loopMode_r ? {1'b0, loopIn_r[7:5], 1'b0, loopIn_r[3:0]} : ctlSync2_r;
    assign dataEff = loopMode_r ? outBuf[outPtr_r] : datSync2_r;
    assign parEff = loopMode_r ? 1'b0 : parSync2_r;
    assign peerStrb = target ? ctlEff[`SETL_CTL_ACK] : ctlEff[`SETL_CTL_REQ];
    assign strbBit = 8'h01 << (target ? `SETL_CTL_REQ : `SETL_CTL_ACK);
    assign ownBits = ownStrb_r ? strbBit : 8'h00;
    assign ctlState = ctlEff[7:0] | ownBits;
    assign busRst = ctlEff[`SETL_CTL_RST];
    assign outByte = msgPh ? outBuf[outPtr_r] : fOutData;
    // ================
    // commands and host side access
    assign cmdWr = regWrStb & (regAddr == `SETL_ADDR_CMD);
    assign startIn = cmdWr & regWrData[`SETL_CMD_START_IN];
    assign startOut = cmdWr & regWrData[`SETL_CMD_START_OUT] & ~startIn;
    assign startAny = startIn | startOut;
    assign errEv = (errDetect | (cmdWr & regWrData[`SETL_CMD_ABORT])) & busy & (state_r != ST_TERM);
    assign hostRd = (regRdStb & (regAddr == `SETL_ADDR_DATA)) | (dmaAck & dirIn_r);
    assign hostWr = (regWrStb & (regAddr == `SETL_ADDR_DATA)) | (dmaAck & ~dirIn_r);
    assign hostWrData = dmaAck ? dmaWrData : regWrData;
    assign hostPop = hostRd & dirIn_r & fOutValid;
    assign hostPush = hostWr & ~dirIn_r & ~halt_r;
    assign oddPad = wide & ~fOutValid2;
    assign popWord = ~fOutValid ? 16'h0000 : (wide ? {(oddPad ? `SETL_PAD_BYTE : fOutData2), fOutData}
        : {8'h00, fOutData});
    assign xferFlag = dirIn_r ? fOutValid : (busy & ~term_r & ~halt_r & (wide ? fInReady2 : fInReady));
    assign residue = dirIn_r ? (modCnt_r[5:0] - dataCnt_r[5:0]) : (dataCnt_r[5:0] - modCnt_r[5:0]);
    // ================
    // fifo hookup
    assign fInValid = dirIn_r ? (evCap & ~msgPh) : hostPush;
    assign fInPair = ~dirIn_r & wide;
    assign fInData = dirIn_r ? dataEff : hostWrData[7:0];
    assign fOutReady = dirIn_r ? hostPop : (evDone & ~msgPh);
    assign fOutPair = dirIn_r & wide & fOutValid2;

    setl_fifo #(.WIDTH(`SETL_FIFO_WIDTH), .DEPTH(`SETL_FIFO_DEPTH)) dataFifo
    (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .flush(startAny),
        .inValid(fInValid),
        .inPair(fInPair),
        .inData(fInData),
        .inData2(hostWrData[15:8]),
        .inReady(fInReady),
        .inReady2(fInReady2),
        .outReady(fOutReady),
        .outPair(fOutPair),
        .outValid(fOutValid),
        .outValid2(fOutValid2),
        .outData(fOutData),
        .outData2(fOutData2)
    );
    // ================
    // handshake engine
    always @*
    begin
        stateNxt = state_r;
        evCap = 1'b0;
        evDone = 1'b0;
        goHold = 1'b0;
        case (state_r)
            ST_IDLE: stateNxt = ST_IDLE;
            ST_WAIT:
            begin
                if (remain_r == 9'h000)
                    stateNxt = ST_IDLE;
                else if ((msgPh | (dirIn_r ? fInReady : fOutValid)) & (target | peerStrb))
                begin
                    goHold = 1'b1;
                    evCap = dirIn_r & ~target;
                    stateNxt = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if ((widthCnt_r == 4'h0) & (target ? peerStrb : ~peerStrb))
                begin
                    evCap = dirIn_r & target;
                    evDone = 1'b1;
                    stateNxt = ST_REL;
                end
            end
            ST_REL:
            begin
                if (~target | ~peerStrb)
                    stateNxt = ST_WAIT;
            end
            ST_TERM:
            begin
                if (~dirIn_r | ~fOutValid)
                    stateNxt = ST_IDLE;
            end
            default: stateNxt = ST_IDLE;
        endcase
        if (errEv | busRst)
        begin
            evCap = 1'b0;
            evDone = 1'b0;
            goHold = 1'b0;
            stateNxt = busRst ? ST_IDLE : ST_TERM;
        end
        ownStrbNxt = goHold | (ownStrb_r & ~evDone & ~errEv & ~busRst);
    end

    assign inBufWr = (evCap & msgPh) | (evDone & ~dirIn_r & loopMode_r);
    assign inBufData = dirIn_r ? dataEff : dataOut_r;

    // ================
    // message buffers
    always @(posedge mclk)
    begin
        if (regWrStb & (regAddr == `SETL_ADDR_OBUF))
            outBuf[swOutPtr_r] <= regWrData[7:0];
        if (inBufWr)
            inBuf[inPtr_r] <= inBufData;
    end

    // ================
    // control and status state
    integer i;
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctlSync1_r <= 9'h000;
            ctlSync2_r <= 9'h000;
            datSync1_r <= 8'h00;
            datSync2_r <= 8'h00;
            parSync1_r <= 1'b0;
            parSync2_r <= 1'b0;
            cfg_r <= `SETL_CFG_RESET;
            len_r <= `SETL_LEN_RESET;
            loopIn_r <= 8'h00;
            ownId_r <= 3'h0;
            for (i = 0; i < 8; i = i + 1)
                syncTbl[i] <= 4'h0;
            loopMode_r <= 1'b0;
            dirIn_r <= 1'b0;
            state_r <= ST_IDLE;
            ownStrb_r <= 1'b0;
            widthCnt_r <= 4'h0;
            remain_r <= 9'h000;
            term_r <= 1'b0;
            halt_r <= 1'b0;
            modCnt_r <= 8'h00;
            dataCnt_r <= 8'h00;
            outPtr_r <= 5'h00;
            inPtr_r <= 5'h00;
            swOutPtr_r <= 5'h00;
            swInPtr_r <= 5'h00;
            parLast_r <= 1'b0;
            rdData_r <= 16'h0000;
            dmaRdData_r <= 16'h0000;
            dmaReq_r <= 1'b0;
            ctlOut_r <= 8'h00;
            ctlOe_r <= 8'h00;
            dataOut_r <= 8'h00;
            parOut_r <= 1'b0;
            dataOe_r <= 1'b0;
        end
        else
        begin
            ctlSync1_r <= scsiCtlIn;
            ctlSync2_r <= ctlSync1_r;
            datSync1_r <= scsiDataIn;
            datSync2_r <= datSync1_r;
            parSync1_r <= scsiParIn;
            parSync2_r <= parSync1_r;
            // register writes
            if (regWrStb)
            begin
                case (regAddr)
                    `SETL_ADDR_CFG: cfg_r <= regWrData[4:0];
                    `SETL_ADDR_LEN: len_r <= regWrData[7:0];
                    `SETL_ADDR_LOOP: loopIn_r <= regWrData[7:0];
                    `SETL_ADDR_SELID: ownId_r <= regWrData[2:0];
                    `SETL_ADDR_SYNC: syncTbl[ownId_r] <= regWrData[3:0];
                    `SETL_ADDR_OBUF: swOutPtr_r <= swOutPtr_r + 5'h01;
                    default: ;
                endcase
            end
            if (cmdWr & regWrData[`SETL_CMD_LOOP_ENTRY])
                loopMode_r <= 1'b1;
            else if (cmdWr & regWrData[`SETL_CMD_LOOP_EXIT])
                loopMode_r <= 1'b0;
            if (cmdWr & regWrData[`SETL_CMD_PTR_CLR])
            begin
                swOutPtr_r <= 5'h00;
                swInPtr_r <= 5'h00;
            end
            else if (regRdStb & (regAddr == `SETL_ADDR_IBUF))
                swInPtr_r <= swInPtr_r + 5'h01;
            // engine
            state_r <= startAny ? ST_WAIT : stateNxt;
            ownStrb_r <= ownStrbNxt;
            if (startAny)
            begin
                dirIn_r <= startIn;
                remain_r <= (len_r == 8'h00) ? `SETL_LEN_FULL : {1'b0, len_r};
                term_r <= 1'b0;
                halt_r <= 1'b0;
                modCnt_r <= 8'h00;
                dataCnt_r <= 8'h00;
                outPtr_r <= 5'h00;
                inPtr_r <= 5'h00;
                dataOut_r <= outByte;
                parOut_r <= ~^outByte;
            end
            else
            begin
                if (errEv)
                begin
                    term_r <= 1'b1;
                    halt_r <= ~dirIn_r;
                end
                if (goHold)
                    widthCnt_r <= cfg_r[`SETL_CFG_SYNC] ? syncTbl[ownId_r] : 4'h0;
                else if (widthCnt_r != 4'h0)
                    widthCnt_r <= widthCnt_r - 4'h1;
                if (goHold & ~dirIn_r)
                begin
                    dataOut_r <= outByte;
                    parOut_r <= ~^outByte;
                end
                if (evCap)
                begin
                    parLast_r <= parEff;
                    modCnt_r <= modCnt_r + 8'h01;
                end
                if (evDone)
                    remain_r <= remain_r - 9'h001;
                if (evDone & ~dirIn_r)
                    modCnt_r <= modCnt_r + 8'h01;
                // outgoing buffer read pointer wraps for reuse
                if ((evCap & loopMode_r) | (evDone & ~dirIn_r & msgPh))
                    outPtr_r <= outPtr_r + 5'h01;
                if (inBufWr)
                    inPtr_r <= inPtr_r + 5'h01;
                // host side byte count, padded final word not counted
                if (hostPop)
                    dataCnt_r <= dataCnt_r + (wide ? (oddPad ? 8'h00 : 8'h02) : 8'h01);
                else if (hostPush & (wide ? fInReady2 : fInReady))
                    dataCnt_r <= dataCnt_r + (wide ? 8'h02 : 8'h01);
            end
            // pins, output enables silenced in loopback
            ctlOut_r <= ownStrbNxt ? strbBit : 8'h00;
            ctlOe_r <= (ownStrbNxt & ~loopMode_r) ? strbBit : 8'h00;
            dataOe_r <= ~loopMode_r & ~dirIn_r & busy & (state_r != ST_TERM);
            dmaReq_r <= useDma & xferFlag;
            dmaRdData_r <= (dmaAck & dirIn_r) ? popWord : 16'h0000;
            // read port
            rdData_r <= 16'h0000;
            if (regRdStb)
            begin
                case (regAddr)
                    `SETL_ADDR_DATA: rdData_r <= popWord;
                    `SETL_ADDR_CFG: rdData_r <= {11'h000, cfg_r};
                    `SETL_ADDR_STAT: rdData_r <= {9'h000, parLast_r, halt_r, ~fOutValid,
                        loopMode_r, xferFlag & ~useDma, term_r, busy};
                    `SETL_ADDR_MODCNT: rdData_r <= {8'h00, modCnt_r};
                    `SETL_ADDR_DATACNT: rdData_r <= {8'h00, dataCnt_r};
                    `SETL_ADDR_LEN: rdData_r <= {8'h00, len_r};
                    `SETL_ADDR_IBUF: rdData_r <= {8'h00, inBuf[swInPtr_r]};
                    `SETL_ADDR_RESID: rdData_r <= {10'h000, residue};
                    `SETL_ADDR_LOOP: rdData_r <= {8'h00, ctlState};
                    default: rdData_r <= 16'h0000;
                endcase
            end
        end
    end

    assign regRdData = rdData_r;
    assign dmaRdData = dmaRdData_r;
    assign dmaReq = dmaReq_r;
    assign scsiCtlOut = ctlOut_r;
    assign scsiCtlOe = ctlOe_r;
    assign scsiDataOut = dataOut_r;
    assign scsiParOut = parOut_r;
    assign scsiDataOe = dataOe_r;
endmodule // setl_top

// [design/setl_defines.vh]
// register map, field positions and fixed sizes of the terminate and loopback block
`ifndef SETL_DEFINES_VH
`define SETL_DEFINES_VH
// register offsets
`define SETL_ADDR_DATA 8'h00
`define SETL_ADDR_CMD 8'h01
`define SETL_ADDR_CFG 8'h02
`define SETL_ADDR_STAT 8'h03
`define SETL_ADDR_MODCNT 8'h04
`define SETL_ADDR_DATACNT 8'h05
`define SETL_ADDR_LEN 8'h06
`define SETL_ADDR_OBUF 8'h07
`define SETL_ADDR_IBUF 8'h08
`define SETL_ADDR_SELID 8'h09
`define SETL_ADDR_SYNC 8'h0A
`define SETL_ADDR_RESID 8'h0C
`define SETL_ADDR_LOOP 8'h11
// command bits
`define SETL_CMD_START_IN 0
`define SETL_CMD_START_OUT 1
`define SETL_CMD_LOOP_ENTRY 2
`define SETL_CMD_LOOP_EXIT 3
`define SETL_CMD_ABORT 4
`define SETL_CMD_PTR_CLR 5
// configuration bits
`define SETL_CFG_DMA 0
`define SETL_CFG_WIDE 1
`define SETL_CFG_TARGET 2
`define SETL_CFG_MSG 3
`define SETL_CFG_SYNC 4
// status bits
`define SETL_ST_BUSY 0
`define SETL_ST_TERM 1
`define SETL_ST_XREQ 2
`define SETL_ST_LOOP 3
`define SETL_ST_EMPTY 4
`define SETL_ST_HALT 5
`define SETL_ST_PAR 6
// bus control signal positions
`define SETL_CTL_IO 0
`define SETL_CTL_CD 1
`define SETL_CTL_MSG 2
`define SETL_CTL_BSY 3
`define SETL_CTL_SEL 4
`define SETL_CTL_ATN 5
`define SETL_CTL_ACK 6
`define SETL_CTL_REQ 7
`define SETL_CTL_RST 8
// sizes and reset values
`define SETL_FIFO_WIDTH 8
`define SETL_FIFO_DEPTH 8
`define SETL_MBUF_DEPTH 32
`define SETL_PAD_BYTE 8'h00
`define SETL_CFG_RESET 5'h00
`define SETL_LEN_RESET 8'h00
`define SETL_LEN_FULL 9'h100
`endif

// [tb/setl_sva.sv]
// port assertions for the terminate and loopback block
`timescale 1ns/1ps
module setl_sva
(
    // clock and reset
    input wire mclk,
    input wire sys_rst,
    // register port
    input wire [7:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWrStb,
    input wire regRdStb,
    input wire [15:0] regRdData,
    // error and dma
    input wire errDetect,
    input wire dmaReq,
    // scsi bus
    input wire [7:0] scsiCtlOut,
    input wire [7:0] scsiCtlOe,
    input wire [7:0] scsiDataOut,
    input wire scsiParOut,
    input wire scsiDataOe
);
    reg loopMode_r;
    reg rdLoop_r;
    reg rdOff_r;
    reg [7:0] loopIn_r;
    wire strobeOn;
    assign strobeOn = |(scsiCtlOut[7:6] & scsiCtlOe[7:6]);
    // ================
    // mode, loopback inputs and read tracking
    always @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            loopMode_r <= 1'b0;
            loopIn_r <= 8'h00;
            rdLoop_r <= 1'b0;
            rdOff_r <= 1'b0;
        end
        else
        begin
            if (regWrStb && regAddr == 8'h01 && (regWrData[2] || regWrData[3]))
                loopMode_r <= regWrData[2];
            if (regWrStb && regAddr == 8'h11)
                loopIn_r <= regWrData[7:0];
            rdLoop_r <= regRdStb && regAddr == 8'h11 && loopMode_r;
            rdOff_r <= regRdStb && (regAddr == 8'h0B || regAddr > 8'h11);
        end
    end
    // ================
    // assertions
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    a_loop_no_drive:
        assert property (loopMode_r && $past(loopMode_r, 2) |-> scsiCtlOe == 8'h00 && !scsiDataOe)
        else $error("bus driven in loopback");
    a_err_strobe_drop:
        assert property (errDetect && strobeOn |-> ##3 !strobeOn [*5])
        else $error("strobe kept after error");
    a_halt_no_drive:
        assert property (errDetect && scsiDataOe |-> ##3 !scsiDataOe [*4])
        else $error("data driven after error");
    a_loop_sel_zero:
        assert property (rdLoop_r |-> regRdData[4] == 1'b0)
        else $error("select seen in loopback");
    a_loop_inputs:
        assert property (rdLoop_r |-> (regRdData[7:0] & 8'h2F) == (loopIn_r & 8'h2F)
            && (regRdData[7:6] & loopIn_r[7:6]) == loopIn_r[7:6])
        else $error("control state differs from loopback inputs");
    a_read_stands:
        assert property (regRdData != 16'h0000 |-> $past(regRdStb))
        else $error("read data outside its cycle");
    a_unmapped_zero:
        assert property (rdOff_r |-> regRdData == 16'h0000)
        else $error("unmapped read not zero");
    a_data_parity:
        assert property (scsiDataOe |-> scsiParOut == ~^scsiDataOut)
        else $error("output parity not odd");
    a_reset_quiet:
        assert property ($fell(sys_rst) |-> scsiCtlOe == 8'h00 && !scsiDataOe && !dmaReq)
        else $error("outputs active after reset");
    c_err_strobe: cover property (errDetect && strobeOn);
    c_loop_read: cover property (rdLoop_r);
    c_resid_read: cover property (regRdStb && regAddr == 8'h0C);
endmodule // setl_sva

// [tb/setl_peer.sv]
// initiator-side bus partner for the terminate and loopback bench
`timescale 1ns/1ps
module setl_peer
(
    // control
    input wire mclk,
    input wire en,
    input wire noise,
    // device pins
    input wire [7:0] ctlOut,
    input wire [7:0] ctlOe,
    input wire [7:0] dataOut,
    input wire parOut,
    input wire dataOe,
    // wire levels back to the device, and the last byte taken for the bench
    output wire [8:0] ctlIn,
    output wire [7:0] dataIn,
    output wire parIn,
    output reg [7:0] lastByte_r = 8'h00
);
    reg ack_r = 1'b0;
    reg [7:0] pat_r = 8'h00;
    wire reqOn;
    assign reqOn = ctlOut[7] & ctlOe[7];
    // wired levels; released data lines keep changing
    assign ctlIn = noise ? {1'b1, pat_r} : {1'b0, ctlOut & ctlOe} | {2'b00, ack_r, 6'h00};
    assign dataIn = dataOe ? dataOut : ~pat_r;
    assign parIn = dataOe ? parOut : pat_r[0];
    // acknowledge each request, take the byte
    always @(posedge mclk)
    begin
        pat_r <= pat_r + 8'h01;
        ack_r <= en & reqOn;
        if (en && reqOn && !ack_r)
            lastByte_r <= dataOut;
    end
endmodule // setl_peer

// [tb/setl_top_tb.sv]
// self-checking bench for the terminate and loopback block
`timescale 1ns/1ps
module setl_top_tb;
    reg mclk, sys_rst, regWrStb, regRdStb, errDetect, peerEn, noise;
    reg [7:0] regAddr;
    reg [15:0] regWrData, rv, tmp;
    wire [15:0] regRdData;
    wire [7:0] scsiCtlOut, scsiCtlOe, scsiDataOut, scsiDataIn, lastByte;
    wire [8:0] scsiCtlIn;
    wire scsiParOut, scsiDataOe, scsiParIn, dmaReq;
    integer mismatches, compares, i, k;
    // ================
    // design and partner
    setl_top dut (.*, .dmaAck(1'b0), .dmaWrData(16'h0000), .dmaRdData());
    setl_peer peer
    (
        .mclk(mclk), .en(peerEn), .noise(noise), .ctlOut(scsiCtlOut), .ctlOe(scsiCtlOe),
        .dataOut(scsiDataOut), .parOut(scsiParOut), .dataOe(scsiDataOe), .ctlIn(scsiCtlIn),
        .dataIn(scsiDataIn), .parIn(scsiParIn), .lastByte_r(lastByte)
    );
    // ================
    // bus and check tasks
    task wr(input [7:0] a, input [15:0] d);
    begin
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge mclk);
        regWrStb <= 1'b0;
    end
    endtask
    task rd(input [7:0] a);
    begin
        @(posedge mclk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge mclk);
        regRdStb <= 1'b0;
        #1;
        rv = regRdData;
    end
    endtask
    task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
        compares = compares + 1;
        if (g !== e)
        begin
            mismatches = mismatches + 1;
            $display("mismatch %0s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task waitReq(input lv);
    begin
        rd(8'h11);
        for (k = 0; k < 40 && rv[7] !== lv; k = k + 1)
            rd(8'h11);
        chk("req", {15'h0000, lv}, {15'h0000, rv[7]});
    end
    endtask
    task hs;
    begin
        waitReq(1'b1);
        wr(8'h11, 16'h0040);
        waitReq(1'b0);
        wr(8'h11, 16'h0000);
    end
    endtask
    task errPulse;
    begin
        @(posedge mclk);
        errDetect <= 1'b1;
        @(posedge mclk);
        errDetect <= 1'b0;
    end
    endtask
    // ================
    // scenarios
    task testReset;
    begin
        rd(8'h02);
        chk("cfg", 16'h0000, rv);
        rd(8'h06);
        chk("len", 16'h0000, rv);
        rd(8'h03);
        chk("stat", 16'h0010, rv & 16'h003F);
        rd(8'h0B);
        chk("unmapped", 16'h0000, rv);
        $display("reset test done");
    end
    endtask
    task testLoopCtl;
    begin
        wr(8'h01, 16'h0004);
        rd(8'h03);
        chk("loop", 16'h0008, rv & 16'h0008);
        @(posedge mclk);
        noise <= 1'b1;
        wr(8'h11, 16'h00FF);
        rd(8'h11);
        chk("ctlstate", 16'h00EF, rv & 16'h00FF);
        chk("oe", 16'h0000, {7'h00, scsiDataOe, scsiCtlOe});
        wr(8'h11, 16'h0000);
        rd(8'h11);
        chk("ctlstate", 16'h0000, rv);
        @(posedge mclk);
        noise <= 1'b0;
        $display("loopback control test done");
    end
    endtask
    task testLoopRecv;
    begin
        wr(8'h01, 16'h0020);
        for (i = 0; i < 32; i = i + 1)
            wr(8'h07, {8'h00, 3'b010, i[4:0]});
        wr(8'h09, 16'h0003);
        wr(8'h0A, 16'h0002);
        wr(8'h02, 16'h0014);
        wr(8'h06, 16'h0022);
        wr(8'h01, 16'h0001);
        for (i = 0; i < 34; i = i + 1)
        begin
            hs;
            rd(8'h00);
            chk("rxbyte", {8'h00, 3'b010, i[4:0]}, rv & 16'h00FF);
        end
        rd(8'h03);
        chk("parity", 16'h0000, rv & 16'h0040);
        $display("loopback receive test done");
    end
    endtask
    task testLoopSend;
    begin
        wr(8'h02, 16'h0004);
        wr(8'h06, 16'h0022);
        wr(8'h01, 16'h0002);
        for (i = 0; i < 34; i = i + 1)
        begin
            wr(8'h00, {8'h00, 2'b10, i[5:0]});
            hs;
        end
        wr(8'h01, 16'h0020);
        for (i = 0; i < 3; i = i + 1)
        begin
            rd(8'h08);
            chk("ibuf", {8'h00, 2'b10, i < 2, i[4:0]}, rv & 16'h00FF);
        end
        $display("loopback send test done");
    end
    endtask
    task testInErr;
    begin
        wr(8'h02, 16'h0006);
        wr(8'h06, 16'h0008);
        wr(8'h01, 16'h0001);
        for (i = 0; i < 3; i = i + 1)
            hs;
        waitReq(1'b1);
        errPulse;
        waitReq(1'b0);
        repeat (8) @(posedge mclk);
        rd(8'h11);
        chk("reqoff", 16'h0000, rv & 16'h0080);
        rd(8'h03);
        chk("drainreq", 16'h0006, rv & 16'h0006);
        rd(8'h0C);
        chk("resid", (16'h0003 - 16'h0000) & 16'h003F, rv & 16'h003F);
        rd(8'h00);
        chk("word1", 16'h4140, rv);
        rd(8'h00);
        chk("word2", 16'h0042, rv);
        rd(8'h04);
        tmp = rv;
        rd(8'h05);
        chk("datcnt", 16'h0002, rv);
        chk("modcnt", rv + 16'h0001, tmp);
        rd(8'h03);
        chk("drained", 16'h0010, rv & 16'h0014);
        $display("input terminate test done");
    end
    endtask
    task testOutErr;
    begin
        wr(8'h01, 16'h0008);
        wr(8'h02, 16'h0004);
        wr(8'h06, 16'h0010);
        wr(8'h01, 16'h0002);
        @(posedge mclk);
        peerEn <= 1'b1;
        wr(8'h00, 16'h00A1);
        wr(8'h00, 16'h00A2);
        rd(8'h04);
        for (k = 0; k < 40 && rv !== 16'h0002; k = k + 1)
            rd(8'h04);
        chk("sent", 16'h00A2, {8'h00, lastByte});
        @(posedge mclk);
        peerEn <= 1'b0;
        for (i = 3; i < 6; i = i + 1)
            wr(8'h00, {12'h00A, i[3:0]});
        repeat (10) @(posedge mclk);
        errPulse;
        wr(8'h00, 16'h00A6);
        rd(8'h03);
        chk("halt", 16'h0020, rv & 16'h0030);
        rd(8'h05);
        chk("datcnt", 16'h0005, rv);
        rd(8'h04);
        chk("modcnt", 16'h0002, rv);
        rd(8'h0C);
        chk("resid", (16'h0005 - 16'h0002) & 16'h003F, rv & 16'h003F);
        chk("resume", 16'h0002, 16'h0005 - (rv & 16'h003F));
        $display("output terminate test done");
    end
    endtask
    task results;
    begin
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    // ================
    // clock, sequence and watchdog
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        sys_rst = 1'b1;
        regAddr = 8'h00;
        regWrData = 16'h0000;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        errDetect = 1'b0;
        peerEn = 1'b0;
        noise = 1'b0;
        mismatches = 0;
        compares = 0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        testReset;
        testLoopCtl;
        testLoopRecv;
        testLoopSend;
        testInErr;
        testOutErr;
        results;
    end
    initial
    begin
        repeat (50000) @(posedge mclk);
        mismatches = mismatches + 1;
        results;
    end
endmodule // setl_top_tb
bind setl_top setl_sva sva (.*);
